// ### common/sdpl_defines.svh
// sdpl_defines.svh - abort codes, command bytes, object indices and limits
`ifndef SDPL_DEFINES_SVH
`define SDPL_DEFINES_SVH

`define AB_TOGGLE    32'h05030000
`define AB_CMD       32'h05040001
`define AB_CPLT      32'h06010000
`define AB_RO        32'h06010002
`define AB_NOOBJ     32'h06020000
`define AB_NOMAP     32'h06040041
`define AB_MAPLEN    32'h06040042
`define AB_LONG      32'h06070012
`define AB_SHORT     32'h06070013
`define AB_NOSUB     32'h06090011
`define AB_HIGH      32'h06090031
`define AB_LOW       32'h06090032
`define AB_GEN       32'h08000000
`define AB_STATE     32'h08000022
`define AB_NONE      32'h00000000

`define CMD_DL_MASK  8'hf3
`define CMD_DL       8'h23
`define CMD_UL       8'h40
`define CMD_SEG_MASK 8'hef
`define CMD_SEG      8'h60
`define CMD_ABORT    8'h80
`define CMD_DL_OK    8'h60
`define CMD_UL_EXP   8'h43
`define CMD_UL_SEG   8'h41
`define CCS_DL       3'h1
`define CCS_UL       3'h2
`define CPLT_BIT     4
`define TOG_BIT      4

`define MAX_EXP      5'h04
`define SEG_BYTES    5'h07
`define STR_LEN      5'h11
`define PDO_MAX_BITS 9'h040
`define BYTE_ROUND   8'h07
`define NMT_OPER     2'h2
`define MAP_SUBS     8'h08
`define MAP_DEPTH    16

`define IX_DEVTYPE   16'h1000
`define IX_ERRF      16'h1003
`define IX_SWVER     16'h100a
`define IX_RXCOM     12'h140
`define IX_RXMAP     12'h160
`define IX_TXCOM     12'h180
`define IX_TXMAP     12'h1a0
`define IX_PDO_LO    16'h1400
`define IX_PDO_HI    16'h1a07
`define IX_CTRL      16'h6040
`define IX_STAT      16'h6041
`define IX_MODE      16'h6060
`define IX_TPOS      16'h607a
`define MODE_MIN     8'h01
`define MODE_MAX     8'h0a

`endif

// ### common/sdpl_pkg.sv
// sdpl_pkg.sv - frame, object descriptor, state and process-data types
package sdpl_pkg;
	// 64-bit image is the 8-byte frame, byte 0 in bits 7:0
	typedef struct packed {
		logic [31:0] data;
		logic [7:0]  sub;
		logic [15:0] idx;
		logic [7:0]  cmd;
	} sdpl_frame_t;

	typedef struct packed {
		logic       exist;
		logic       sub_ok;
		logic       ro;
		logic [4:0] size;
		logic       mappable;
		logic       has_max;
		logic [7:0] max;
		logic       has_min;
		logic [7:0] min;
	} sdpl_obj_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_LOOK  = 2'h1,
		ST_CHECK = 2'h3
	} sdpl_state_t;

	typedef struct packed {
		logic       tx;
		logic [2:0] num;
		logic [3:0] len;
	} sdpl_pdo_t;
endpackage

// ### design/sdpl_od_lookup.sv
// sdpl_od_lookup.sv - object dictionary descriptor table
`timescale 1ns/1ns
`default_nettype none
`include "sdpl_defines.svh"

module sdpl_od_lookup (
	input  wire logic [15:0]        i_idx,
	input  wire logic [7:0]         i_sub,
	output sdpl_pkg::sdpl_obj_t     o_obj
);
	wire com = (i_idx[15:4] == `IX_RXCOM || i_idx[15:4] == `IX_TXCOM) && !i_idx[3];
	wire map = (i_idx[15:4] == `IX_RXMAP || i_idx[15:4] == `IX_TXMAP) && !i_idx[3];
	wire s0  = i_sub == 8'h00;

	always_comb begin
		o_obj = '0;
		o_obj.exist = 1'b1;
		o_obj.sub_ok = s0;
		if (i_idx == `IX_DEVTYPE) begin
			o_obj.ro = 1'b1;
			o_obj.size = 5'h04;
		end else if (i_idx == `IX_ERRF) begin
			o_obj.sub_ok = i_sub <= 8'h01;
			o_obj.ro = !s0;
			o_obj.size = s0 ? 5'h01 : 5'h04;
			o_obj.has_max = s0;
		end else if (i_idx == `IX_SWVER) begin
			o_obj.ro = 1'b1;
			o_obj.size = `STR_LEN;
		end else if (com) begin
			o_obj.sub_ok = i_sub <= 8'h02;
			o_obj.ro = s0;
			o_obj.size = (i_sub == 8'h01) ? 5'h04 : 5'h01;
		end else if (map) begin
			o_obj.sub_ok = i_sub <= `MAP_SUBS;
			o_obj.size = s0 ? 5'h01 : 5'h04;
			o_obj.has_max = s0;
			o_obj.max = `MAP_SUBS;
		end else if (i_idx == `IX_CTRL || i_idx == `IX_STAT) begin
			o_obj.ro = i_idx == `IX_STAT;
			o_obj.size = 5'h02;
			o_obj.mappable = 1'b1;
		end else if (i_idx == `IX_MODE) begin
			o_obj.size = 5'h01;
			o_obj.mappable = 1'b1;
			o_obj.has_max = 1'b1;
			o_obj.max = `MODE_MAX;
			o_obj.has_min = 1'b1;
			o_obj.min = `MODE_MIN;
		end else if (i_idx == `IX_TPOS) begin
			o_obj.size = 5'h04;
			o_obj.mappable = 1'b1;
		end else begin
			o_obj.exist = 1'b0;
			o_obj.sub_ok = 1'b0;
		end
	end
endmodule // sdpl_od_lookup

`default_nettype wire

// ### design/sdpl_map_mem.sv
// sdpl_map_mem.sv - mapped bit totals per mapping, two registered read ports
`timescale 1ns/1ns
`default_nettype none
`include "sdpl_defines.svh"

module sdpl_map_mem (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_we,
	input  wire logic [3:0] i_waddr,
	input  wire logic [6:0] i_wdata,
	input  wire logic [3:0] i_raddr_a,
	input  wire logic [3:0] i_raddr_b,
	output logic      [6:0] o_rdata_a,
	output logic      [6:0] o_rdata_b
);
	logic [6:0] mem_q [`MAP_DEPTH];

	// reset empties every mapping so no stale length survives a restart
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < `MAP_DEPTH; i++) mem_q[i] <= 7'h00;
		end else if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		o_rdata_a <= mem_q[i_raddr_a];
		o_rdata_b <= mem_q[i_raddr_b];
	end
endmodule // sdpl_map_mem

`default_nettype wire

// ### design/sdpl_sdo_check.sv
// sdpl_sdo_check.sv - service data request checker and process data admission
//
// Overview of operation
// (RQ1) failed request answers abort with error number
// (RQ2) unchanged segment toggle aborts 05030000
// (RQ3) unknown command byte aborts 05040001
// (RQ4) complete access request aborts 06010000
// (RQ5) write to read-only object aborts 06010002
// (RQ6) unknown index aborts 06020000
// (RQ7) mapping unmappable object aborts 06040041
// (RQ8) mapping beyond eight bytes aborts 06040042
// (RQ9) write length above object size aborts 06070012
// (RQ10) write length below object size aborts 06070013
// (RQ11) unknown subindex aborts 06090011
// (RQ12) value above upper limit aborts 06090031
// (RQ13) error count accepts only zero
// (RQ14) value below lower limit aborts 06090032
// (RQ15) uncategorised failure aborts 08000000
// (RQ16) pdo parameter writes while operational abort 08000022
// (RQ17) process data only while operational
// (RQ18) master configures pdos in pre-operational
// (RQ19) eight mappings, at most 64 bits
// (RQ20) pdo length follows mapped size
// (RQ21) pdo frame carries payload only
// (RQ22) abort ends transfer, restart from initiation
// (RQ23) segment toggle starts at zero each transfer
// (RQ24) write command byte encodes data length
// (RQ25) abort echoes index, subindex, code little-endian
// (RQ26) one code, fixed check priority order
`timescale 1ns/1ns
`default_nettype none
`include "sdpl_defines.svh"

module sdpl_sdo_check (
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_req_valid,
	input  wire sdpl_pkg::sdpl_frame_t i_req,
	input  wire logic [1:0]            i_nmt_state,
	input  wire logic [31:0]           i_rd_data,
	input  wire logic [55:0]           i_seg_data,
	input  wire logic                  i_pdo_valid,
	input  wire sdpl_pkg::sdpl_pdo_t   i_pdo,
	output logic                       o_busy,
	output logic                       o_rsp_valid,
	output sdpl_pkg::sdpl_frame_t      o_rsp,
	output logic [15:0]                o_od_idx,
	output logic [7:0]                 o_od_sub,
	output logic [4:0]                 o_seg_off,
	output logic                       o_wr_stb,
	output logic [31:0]                o_wr_data,
	output logic                       o_pdo_ok,
	output logic                       o_pdo_rej,
	output logic [3:0]                 o_pdo_bytes
);
	sdpl_pkg::sdpl_state_t st_q;
	sdpl_pkg::sdpl_state_t st_d;
	sdpl_pkg::sdpl_frame_t req_q;
	sdpl_pkg::sdpl_frame_t rsp_d;
	sdpl_pkg::sdpl_obj_t   la;
	sdpl_pkg::sdpl_obj_t   lb;
	sdpl_pkg::sdpl_pdo_t   pdo_q;
	logic        seg_act_q;
	logic        tog_q;
	logic [4:0]  rem_q;
	logic        pv_q;
	logic [6:0]  map_a;
	logic [6:0]  map_b;
	logic [31:0] code_d;

	// request decode
	wire [7:0]  cmd      = req_q.cmd;
	wire [31:0] val      = req_q.data;
	wire        is_dl    = (cmd & `CMD_DL_MASK) == `CMD_DL;
	wire        is_ul    = cmd == `CMD_UL;
	wire        is_seg   = (cmd & `CMD_SEG_MASK) == `CMD_SEG;
	wire        is_abt   = cmd == `CMD_ABORT;
	wire        is_cplt  = cmd[`CPLT_BIT] && (cmd[7:5] == `CCS_DL || cmd[7:5] == `CCS_UL);
	wire        cmd_known = is_dl || is_ul || is_seg || is_abt || is_cplt;
	wire        tog_bit  = cmd[`TOG_BIT];
	wire [4:0]  dl_len   = `MAX_EXP - 5'(cmd[3:2]); // [RQ24]
	wire        st_chk   = st_q == sdpl_pkg::ST_CHECK;
	wire        oper     = i_nmt_state == `NMT_OPER;

	// mapping entries and parameter range
	wire is_map  = (req_q.idx[15:4] == `IX_RXMAP || req_q.idx[15:4] == `IX_TXMAP);
	wire map_ent = is_map && req_q.sub != 8'h00;
	wire [3:0] map_wa = {req_q.idx[11], req_q.idx[2:0]};
	wire [8:0] map_sum = 9'(map_a) + 9'(val[7:0]);
	wire tgt_ok  = lb.exist && lb.sub_ok && lb.mappable;
	wire pdo_par = req_q.idx >= `IX_PDO_LO && req_q.idx <= `IX_PDO_HI;
	wire too_hi  = la.has_max && val > {24'h0, la.max};
	wire too_lo  = la.has_min && val < {24'h0, la.min};
	wire long_ul = la.size > `MAX_EXP;

	// segment bookkeeping
	wire       seg_last = rem_q <= `SEG_BYTES;
	wire [4:0] seg_n    = seg_last ? (`SEG_BYTES - rem_q) : 5'h00;
	wire [7:0] seg_cmd  = {3'h0, tog_q, seg_n[2:0], seg_last};
	wire [4:0] ul_gap   = `MAX_EXP - la.size;
	wire [7:0] ul_cmd   = `CMD_UL_EXP | {4'h0, ul_gap[1:0], 2'h0};

	// first failing check wins, command first and state last
	assign code_d =
		!cmd_known                      ? `AB_CMD :    // [RQ3] [RQ26]
		is_cplt                         ? `AB_CPLT :   // [RQ4]
		is_seg ? (!seg_act_q            ? `AB_GEN :    // [RQ15]
		          tog_bit != tog_q      ? `AB_TOGGLE : // [RQ2]
		                                  `AB_NONE) :
		is_abt                          ? `AB_NONE :
		!la.exist                       ? `AB_NOOBJ :  // [RQ6]
		!la.sub_ok                      ? `AB_NOSUB :  // [RQ11]
		is_dl && la.ro                  ? `AB_RO :     // [RQ5]
		is_dl && dl_len > la.size       ? `AB_LONG :   // [RQ9]
		is_dl && dl_len < la.size       ? `AB_SHORT :  // [RQ10]
		is_dl && map_ent && !tgt_ok     ? `AB_NOMAP :  // [RQ7]
		is_dl && map_ent && map_sum > `PDO_MAX_BITS ? `AB_MAPLEN : // [RQ8] [RQ19]
		is_dl && too_hi                 ? `AB_HIGH :   // [RQ12] [RQ13]
		is_dl && too_lo                 ? `AB_LOW :    // [RQ14]
		is_dl && pdo_par && oper        ? `AB_STATE :  // [RQ16]
		                                  `AB_NONE;

	wire fail   = code_d != `AB_NONE;
	wire wr_ok  = st_chk && is_dl && !fail;
	wire map_we = wr_ok && is_map && (map_ent || val == 32'h0);

	// answer frame; abort echoes index and subindex, code in bytes 4..7
	assign rsp_d =
		fail   ? {code_d, req_q.sub, req_q.idx, `CMD_ABORT} :                // [RQ1] [RQ25]
		is_seg ? sdpl_pkg::sdpl_frame_t'({i_seg_data, seg_cmd}) :
		is_dl  ? {32'h0, req_q.sub, req_q.idx, `CMD_DL_OK} :
		long_ul ? {27'h0, la.size, req_q.sub, req_q.idx, `CMD_UL_SEG} :
		          {i_rd_data, req_q.sub, req_q.idx, ul_cmd};

	always_comb begin
		st_d = st_q;
		case (st_q)
			sdpl_pkg::ST_IDLE: begin
				if (i_req_valid) st_d = sdpl_pkg::ST_LOOK;
			end
			sdpl_pkg::ST_LOOK: st_d = sdpl_pkg::ST_CHECK;
			sdpl_pkg::ST_CHECK: st_d = sdpl_pkg::ST_IDLE;
			default: st_d = sdpl_pkg::ST_IDLE;
		endcase
	end

	sdpl_od_lookup u_req_obj (
		.i_idx (req_q.idx),
		.i_sub (req_q.sub),
		.o_obj (la)
	);

	// second lookup judges the object named inside a mapping entry
	sdpl_od_lookup u_map_obj (
		.i_idx (val[31:16]),
		.i_sub (val[15:8]),
		.o_obj (lb)
	);

	sdpl_map_mem u_map (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_we      (map_we),
		.i_waddr   (map_wa),
		.i_wdata   (map_ent ? map_sum[6:0] : 7'h00),
		.i_raddr_a (map_wa),
		.i_raddr_b ({i_pdo.tx, i_pdo.num}),
		.o_rdata_a (map_a),
		.o_rdata_b (map_b)
	);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= sdpl_pkg::ST_IDLE;
			req_q <= '0;
			o_busy <= 1'b0;
		end else begin
			st_q <= st_d;
			o_busy <= st_d != sdpl_pkg::ST_IDLE;
			if (st_q == sdpl_pkg::ST_IDLE && i_req_valid) req_q <= i_req;
		end
	end

	// object pointer holds across segments of one upload
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_od_idx <= 16'h0;
			o_od_sub <= 8'h0;
		end else if (st_q == sdpl_pkg::ST_IDLE && i_req_valid &&
			     (i_req.cmd & `CMD_SEG_MASK) != `CMD_SEG) begin
			o_od_idx <= i_req.idx;
			o_od_sub <= i_req.sub;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rsp_valid <= 1'b0;
			o_rsp <= '0;
			o_wr_stb <= 1'b0;
			o_wr_data <= 32'h0;
		end else begin
			// a received abort is never answered
			o_rsp_valid <= st_chk && !(is_abt && !fail); // [RQ22]
			if (st_chk) o_rsp <= rsp_d;
			o_wr_stb <= wr_ok; // [RQ5]
			if (wr_ok) o_wr_data <= val;
		end
	end

	// segmented upload tracking
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			seg_act_q <= 1'b0;
			tog_q <= 1'b0;
			rem_q <= 5'h0;
			o_seg_off <= 5'h0;
		end else if (st_chk) begin
			if (is_abt || fail) begin
				seg_act_q <= 1'b0; // [RQ22]
				tog_q <= 1'b0;     // [RQ23]
			end else if (is_seg) begin
				tog_q <= ~tog_q;
				seg_act_q <= !seg_last;
				rem_q <= seg_last ? 5'h0 : rem_q - `SEG_BYTES;
				o_seg_off <= o_seg_off + `SEG_BYTES;
			end else begin
				seg_act_q <= is_ul && long_ul;
				tog_q <= 1'b0; // [RQ23]
				rem_q <= la.size;
				o_seg_off <= 5'h0;
			end
		end
	end

	// process data admission: length comes from the stored mapping only
	wire [7:0] pdo_rnd = 8'(map_b) + `BYTE_ROUND;
	wire [3:0] pbytes  = pdo_rnd[6:3]; // [RQ20] [RQ21]
	wire pdo_go = pv_q && oper && pbytes != 4'h0 &&
		      (pdo_q.tx || pdo_q.len == pbytes); // [RQ17] [RQ20]

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pv_q <= 1'b0;
			pdo_q <= '0;
			o_pdo_ok <= 1'b0;
			o_pdo_rej <= 1'b0;
			o_pdo_bytes <= 4'h0;
		end else begin
			pv_q <= i_pdo_valid;
			pdo_q <= i_pdo;
			o_pdo_ok <= pdo_go;
			o_pdo_rej <= pv_q && !pdo_go;
			if (pv_q) o_pdo_bytes <= pbytes;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence abort_s(logic [31:0] c);
		##1 o_rsp_valid && o_rsp.cmd == `CMD_ABORT && o_rsp.data == c;
	endsequence

	sequence no_write_s;
		##1 !o_wr_stb;
	endsequence

	cmd_unknown_a: assert property ( // [RQ3]
		st_chk && !cmd_known |-> abort_s(`AB_CMD))
		else $error("unknown command not aborted");
	toggle_same_a: assert property ( // [RQ2]
		st_chk && is_seg && seg_act_q && tog_bit != tog_q |-> abort_s(`AB_TOGGLE))
		else $error("stale toggle not aborted");
	no_object_a: assert property ( // [RQ6]
		st_chk && (is_dl || is_ul) && !is_cplt && !la.exist |-> abort_s(`AB_NOOBJ))
		else $error("missing object not aborted");
	ro_write_a: assert property ( // [RQ5]
		st_chk && is_dl && la.exist && la.sub_ok && la.ro
		|-> abort_s(`AB_RO) and no_write_s)
		else $error("read-only write not refused");
	len_long_a: assert property ( // [RQ9]
		st_chk && is_dl && la.exist && la.sub_ok && !la.ro && dl_len > la.size
		|-> abort_s(`AB_LONG))
		else $error("long write not refused");
	state_lock_a: assert property ( // [RQ16]
		o_wr_stb && $past(oper) |-> !($past(req_q.idx) >= `IX_PDO_LO &&
		                       $past(req_q.idx) <= `IX_PDO_HI))
		else $error("pdo parameter written while operational");
	abort_echo_a: assert property ( // [RQ25]
		o_rsp_valid && o_rsp.cmd == `CMD_ABORT |-> o_rsp.idx == req_q.idx &&
		o_rsp.sub == req_q.sub && !seg_act_q && !tog_q)
		else $error("abort frame or transfer state wrong");
	pdo_oper_a: assert property ( // [RQ17]
		o_pdo_ok |-> $past(i_nmt_state) == `NMT_OPER && $past(i_pdo_valid, 2))
		else $error("pdo admitted outside operational");
	pdo_size_a: assert property ( // [RQ19]
		o_pdo_ok |-> o_pdo_bytes <= 4'h8 && o_pdo_bytes != 4'h0)
		else $error("pdo length beyond eight bytes");
	seg_start_a: assert property ( // [RQ23]
		o_rsp_valid && o_rsp.cmd == `CMD_UL_SEG |-> !tog_q ##1 !o_rsp_valid)
		else $error("toggle not cleared at segmented start");

	// length and rights already passed, so only mapping, value range and state are left to judge
	wire fit_ok = st_chk && is_dl && la.exist && la.sub_ok && !la.ro && dl_len == la.size;

	cplt_access_a: assert property ( // [RQ4]
		st_chk && is_cplt |-> abort_s(`AB_CPLT))
		else $error("complete access not aborted");
	no_sub_a: assert property ( // [RQ11]
		st_chk && (is_dl || is_ul) && la.exist && !la.sub_ok |-> abort_s(`AB_NOSUB))
		else $error("missing subindex not aborted");
	len_short_a: assert property ( // [RQ10]
		st_chk && is_dl && la.exist && la.sub_ok && !la.ro && dl_len < la.size
		|-> abort_s(`AB_SHORT))
		else $error("short write not refused");
	value_high_a: assert property ( // [RQ12] [RQ13]
		fit_ok && !map_ent && too_hi |-> abort_s(`AB_HIGH) and no_write_s)
		else $error("value above limit not refused");
	value_low_a: assert property ( // [RQ14]
		fit_ok && !map_ent && !too_hi && too_lo |-> abort_s(`AB_LOW) and no_write_s)
		else $error("value below limit not refused");
	seg_idle_a: assert property ( // [RQ15]
		st_chk && is_seg && !seg_act_q |-> abort_s(`AB_GEN))
		else $error("stray segment not aborted");
	abort_quiet_a: assert property ( // [RQ22]
		st_chk && is_abt |-> ##1 !o_rsp_valid && !o_wr_stb)
		else $error("received abort was answered");
	map_limit_a: assert property ( // [RQ8] [RQ19]
		map_we && map_ent |-> map_sum <= `PDO_MAX_BITS)
		else $error("mapping stored beyond sixty-four bits");
	fail_nowrite_a: assert property ( // [RQ5]
		st_chk && fail |-> no_write_s)
		else $error("write strobe after refused request");
	pdo_answer_a: assert property ( // [RQ17]
		pv_q |-> ##1 (o_pdo_ok != o_pdo_rej))
		else $error("pdo decision missing or doubled");
	pdo_len_a: assert property ( // [RQ20]
		o_pdo_ok && !$past(pdo_q.tx) |-> o_pdo_bytes == $past(pdo_q.len))
		else $error("received pdo length differs from mapping");
	abort_code_a: assert property ( // [RQ1]
		o_rsp_valid && o_rsp.cmd == `CMD_ABORT |-> o_rsp.data != `AB_NONE)
		else $error("abort without error number");
endmodule // sdpl_sdo_check

`default_nettype wire

// ### bench/sdpl_client.sv
// sdpl_client.sv - network master model issuing object dictionary requests
`timescale 1ns/1ns
`default_nettype none

module sdpl_client (
	input  wire logic                  i_clk,
	input  wire logic                  i_busy,
	input  wire logic                  i_rsp_valid,
	input  wire sdpl_pkg::sdpl_frame_t i_rsp,
	input  wire logic                  i_wr_stb,
	output logic                       o_req_valid,
	output sdpl_pkg::sdpl_frame_t      o_req
);
	sdpl_pkg::sdpl_frame_t rsp_q;
	logic                  got_q;
	logic                  stb_q;
	logic                  tog_q;

	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
		tog_q = 1'b0;
	end

	// gap idles before the request, so the master can be slow as well as prompt
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
			input logic [31:0] data, input int gap);
		int n;
		repeat (gap) @(posedge i_clk);
		n = 0;
		while (i_busy !== 1'b0 && n < 20) begin
			@(posedge i_clk);
			n++;
		end
		o_req_valid <= 1'b1;
		o_req <= {data, sub, idx, cmd};
		@(posedge i_clk);
		o_req_valid <= 1'b0;
		// a released request never shows its last value
		o_req <= ~{data, sub, idx, cmd};
		got_q = 1'b0;
		stb_q = 1'b0;
		rsp_q = 'x;
		n = 0;
		while (got_q == 1'b0 && n < 6) begin
			@(posedge i_clk);
			if (i_rsp_valid === 1'b1) begin
				got_q = 1'b1;
				rsp_q = i_rsp;
				stb_q = i_wr_stb;
			end
			n++;
		end
		if (cmd == 8'h80 || rsp_q.cmd === 8'h80) begin
			tog_q = 1'b0;
		end
	endtask

	task automatic write(input logic [15:0] idx, input logic [7:0] sub, input int len,
			input logic [31:0] data);
		xfer(8'h23 | 8'((4 - len) << 2), idx, sub, data, 0);
	endtask

	task automatic upload(input logic [15:0] idx);
		tog_q = 1'b0;
		xfer(8'h40, idx, 8'h00, 32'h0, 2);
	endtask

	// same = 1 repeats the previous toggle on purpose
	task automatic seg(input logic same);
		xfer({3'h3, tog_q ^ same, 4'h0}, 16'h0, 8'h00, 32'h0, 1);
		if (rsp_q.cmd !== 8'h80) begin
			tog_q = ~tog_q;
		end
	endtask
endmodule // sdpl_client

`default_nettype wire

// ### bench/tb_sdo_abort_and_pdo_limits.sv
// tb_sdo_abort_and_pdo_limits.sv - self-checking bench for the request checker
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) chk(64'(g), 64'(e));

module tb_sdo_abort_and_pdo_limits;
	logic                  clk;
	logic                  rst;
	logic [1:0]            nmt;
	logic [31:0]           rd_data;
	logic [55:0]           seg_data;
	logic                  pdo_valid;
	sdpl_pkg::sdpl_pdo_t   pdo;
	logic                  req_valid;
	sdpl_pkg::sdpl_frame_t req;
	logic                  busy;
	logic                  rsp_valid;
	sdpl_pkg::sdpl_frame_t rsp;
	logic [15:0]           od_idx;
	logic [7:0]            od_sub;
	logic [4:0]            seg_off;
	logic                  wr_stb;
	logic [31:0]           wr_data;
	logic                  pdo_ok;
	logic                  pdo_rej;
	logic [3:0]            pdo_bytes;
	int                    n_mismatch;
	int                    checks;

	sdpl_sdo_check i_dut (
		.i_clk       (clk),
		.i_sys_rst   (rst),
		.i_req_valid (req_valid),
		.i_req       (req),
		.i_nmt_state (nmt),
		.i_rd_data   (rd_data),
		.i_seg_data  (seg_data),
		.i_pdo_valid (pdo_valid),
		.i_pdo       (pdo),
		.o_busy      (busy),
		.o_rsp_valid (rsp_valid),
		.o_rsp       (rsp),
		.o_od_idx    (od_idx),
		.o_od_sub    (od_sub),
		.o_seg_off   (seg_off),
		.o_wr_stb    (wr_stb),
		.o_wr_data   (wr_data),
		.o_pdo_ok    (pdo_ok),
		.o_pdo_rej   (pdo_rej),
		.o_pdo_bytes (pdo_bytes)
	);

	sdpl_client i_cli (
		.i_clk       (clk),
		.i_busy      (busy),
		.i_rsp_valid (rsp_valid),
		.i_rsp       (rsp),
		.i_wr_stb    (wr_stb),
		.o_req_valid (req_valid),
		.o_req       (req)
	);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	// object storage stand-in: every string byte carries the segment's offset
	always @(posedge clk) begin
		rd_data <= {od_idx, od_sub, 8'h5a};
		seg_data <= {7{3'h0, seg_off}};
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic ab(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
			input logic [31:0] data, input logic [31:0] code);
		i_cli.xfer(cmd, idx, sub, data, 0);
		`CHK(i_cli.rsp_q, {code, sub, idx, 8'h80})
		`CHK(i_cli.stb_q, 1'b0)
	endtask

	task automatic t_dl();
		i_cli.write(16'h607a, 8'h00, 4, 32'h3e8);
		`CHK(i_cli.rsp_q, {32'h0, 8'h00, 16'h607a, 8'h60})
		`CHK({i_cli.stb_q, wr_data}, {1'b1, 32'h3e8})
		i_cli.write(16'h6060, 8'h00, 1, 32'h0a);
		`CHK({i_cli.stb_q, i_cli.rsp_q.cmd, wr_data}, {1'b1, 8'h60, 32'h0a})
		i_cli.write(16'h1003, 8'h00, 1, 32'h0);
		`CHK({i_cli.stb_q, i_cli.rsp_q.cmd, wr_data}, {1'b1, 8'h60, 32'h0})
		i_cli.upload(16'h6041);
		`CHK(i_cli.rsp_q, {32'h6041005a, 8'h00, 16'h6041, 8'h4b})
		$display("test download done");
	endtask

	task automatic t_aborts();
		ab(8'ha0, 16'h607a, 8'h00, 32'h0, 32'h05040001);
		ab(8'h50, 16'h607a, 8'h00, 32'h0, 32'h06010000);
		ab(8'h23, 16'h1000, 8'h00, 32'h5, 32'h06010002);
		ab(8'h40, 16'h2000, 8'h00, 32'h0, 32'h06020000);
		ab(8'h2f, 16'h2000, 8'h00, 32'h0, 32'h06020000);
		ab(8'h40, 16'h6040, 8'h05, 32'h0, 32'h06090011);
		ab(8'h23, 16'h6060, 8'h00, 32'h5, 32'h06070012);
		ab(8'h2f, 16'h607a, 8'h00, 32'h1, 32'h06070013);
		ab(8'h2f, 16'h6060, 8'h00, 32'h0b, 32'h06090031);
		ab(8'h2f, 16'h6060, 8'h00, 32'h0, 32'h06090032);
		ab(8'h2f, 16'h1003, 8'h00, 32'h1, 32'h06090031);
		ab(8'h23, 16'h1600, 8'h01, 32'h10000020, 32'h06040041);
		ab(8'h60, 16'h100a, 8'h00, 32'h0, 32'h08000000);
		$display("test aborts done");
	endtask

	task automatic t_seg();
		i_cli.upload(16'h100a);
		`CHK(i_cli.rsp_q, {32'h11, 8'h00, 16'h100a, 8'h41})
		i_cli.seg(1'b0);
		`CHK(i_cli.rsp_q.cmd, 8'h00)
		i_cli.seg(1'b0);
		`CHK(i_cli.rsp_q, {{7{8'h07}}, 8'h10})
		i_cli.seg(1'b1);
		`CHK({i_cli.rsp_q.data, i_cli.rsp_q.cmd}, {32'h05030000, 8'h80})
		i_cli.seg(1'b0);
		`CHK({i_cli.rsp_q.data, i_cli.rsp_q.cmd}, {32'h08000000, 8'h80})
		i_cli.upload(16'h100a);
		i_cli.seg(1'b0);
		i_cli.xfer(8'h80, 16'h100a, 8'h00, 32'h0, 0);
		`CHK(i_cli.got_q, 1'b0)
		i_cli.seg(1'b0);
		`CHK({i_cli.rsp_q.data, i_cli.rsp_q.cmd}, {32'h08000000, 8'h80})
		i_cli.upload(16'h100a);
		i_cli.seg(1'b0);
		`CHK(i_cli.rsp_q.cmd, 8'h00)
		i_cli.seg(1'b0);
		i_cli.seg(1'b0);
		`CHK(i_cli.rsp_q.cmd, 8'h09)
		$display("test segments done");
	endtask

	// frames carry only direction, mapping number and length
	task automatic pd(input logic tx, input logic [2:0] num, input logic [3:0] len,
			input logic ok, input logic [3:0] nb);
		pdo_valid <= 1'b1;
		pdo <= {tx, num, len};
		@(posedge clk);
		pdo_valid <= 1'b0;
		pdo <= ~{tx, num, len};
		repeat (2) @(posedge clk);
		`CHK({pdo_ok, pdo_rej}, {ok, ~ok})
		if (ok) begin
			`CHK(pdo_bytes, nb)
		end
	endtask

	task automatic t_pdo();
		i_cli.write(16'h1600, 8'h00, 1, 32'h0);
		i_cli.write(16'h1600, 8'h01, 4, 32'h60400010);
		i_cli.write(16'h1600, 8'h02, 4, 32'h607a0020);
		i_cli.write(16'h1a07, 8'h01, 4, 32'h60410010);
		`CHK(i_cli.rsp_q.cmd, 8'h60)
		ab(8'h23, 16'h1600, 8'h03, 32'h607a0020, 32'h06040042);
		pd(1'b0, 3'h0, 4'h6, 1'b0, 4'h0);
		nmt <= 2'h2;
		@(posedge clk);
		pd(1'b0, 3'h0, 4'h6, 1'b1, 4'h6);
		pd(1'b0, 3'h0, 4'h5, 1'b0, 4'h0);
		pd(1'b1, 3'h0, 4'h0, 1'b0, 4'h0);
		pd(1'b1, 3'h7, 4'h0, 1'b1, 4'h2);
		ab(8'h2f, 16'h1400, 8'h02, 32'hff, 32'h08000022);
		ab(8'h23, 16'h1a07, 8'h01, 32'h60410010, 32'h08000022);
		$display("test process data done");
	endtask

	initial begin
		n_mismatch = 0;
		checks = 0;
		rst = 1'b1;
		nmt = 2'h0;
		pdo_valid = 1'b0;
		pdo = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_dl();
		t_aborts();
		t_seg();
		t_pdo();
		close_out();
	end

	initial begin
		#(40 * 4000);
		n_mismatch++;
		$display("watchdog expired");
		close_out();
	end
endmodule // tb_sdo_abort_and_pdo_limits

`default_nettype wire
